//--- rtl/swk_bcd_chain.sv
/*
  Three-digit BCD counter with clear and decisecond overflow pulse.
  Assumes inc is a one-cycle pulse; clear wins over increment.
*/
`timescale 1ns/1ns
`default_nettype none
module swk_bcd_chain (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic       clr,
  input  wire logic       inc,
  // Digits
  output logic [3:0]      ms,
  output logic [3:0]      cs,
  output logic [3:0]      ds,
  output logic            carry
);
  import swk_pkg::*;

  logic ms_wrap;
  logic cs_wrap;
  logic ds_wrap;

  assign ms_wrap = (ms == BCD_MAX);
  assign cs_wrap = ms_wrap && (cs == BCD_MAX);
  assign ds_wrap = cs_wrap && (ds == BCD_MAX);

  // Digit ripple
  always_ff @(posedge clk) begin
    if (srst || clr) begin
      ms <= NIB_ZERO;
      cs <= NIB_ZERO;
      ds <= NIB_ZERO;
    end else if (inc) begin
      ms <= ms_wrap ? NIB_ZERO : ms + BCD_ONE;
      if (ms_wrap) cs <= cs_wrap ? NIB_ZERO : cs + BCD_ONE;
      if (cs_wrap) ds <= ds_wrap ? NIB_ZERO : ds + BCD_ONE;
    end
  end

  // Carry into seconds
  always_ff @(posedge clk) begin
    if (srst) begin
      carry <= 1'b0;
    end else begin
      carry <= inc && !clr && ds_wrap;
    end
  end

endmodule
`default_nettype wire

//--- rtl/swk_key_filter.sv
/*
  One key input: two-stage synchroniser, sampling on the tick and
  release chatter filter.
  Assumes tick is a one-cycle pulse at 1,024 Hz; pressed is high.
*/
`timescale 1ns/1ns
`default_nettype none
module swk_key_filter #(
  parameter int DEB_TICKS = swk_pkg::DEB_TICKS
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Sampling
  input  wire logic tick,
  input  wire logic raw,
  // Filtered key
  output logic      level,
  output logic      press
);
  import swk_pkg::*;

  localparam int CW = $clog2(DEB_TICKS + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(DEB_TICKS - 1);

  initial begin
    if (DEB_TICKS < 2) $error("swk_key_filter: DEB_TICKS too small");
  end

  logic          s1_reg;
  logic          s2_reg;
  logic [CW-1:0] rel_reg;

  // Pin synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end

  // Press on first high sample, release only after a quiet spell
  always_ff @(posedge clk) begin
    if (srst) begin
      level   <= 1'b0;
      press   <= 1'b0;
      rel_reg <= '0;
    end else begin
      press <= 1'b0;
      if (tick) begin
        if (s2_reg) begin
          rel_reg <= '0;
          level   <= 1'b1;
          press   <= ~level;
        end else if (level) begin
          rel_reg <= rel_reg + CW'(1);
          if (rel_reg == CNT_LAST) begin
            level   <= 1'b0;
            rel_reg <= '0;
          end
        end
      end
    end
  end

  a_press_pulse: assert property (@(posedge clk) disable iff (srst)
    press |-> level && !$past(level))
    else $error("press without rising level");

endmodule
`default_nettype wire

//--- rtl/swk_pkg.sv
/*
  Constants, register map and shared helpers for the stopwatch capture
  and direct key block.
  Assumes a 100 MHz system clock and a 4-bit register port.
*/
//
// Overview of operation
// - Millisecond read latches all digits, starts hold
// - Hold lasts until decisecond digit read
// - Unheld centi/deci read returns live count
// - Lap during hold overwrites; hold persists
// - Renewal flag set on decisecond read after overwrite
// - Run bit write acts on next tick
// - Stopped counter keeps value, resumes later
// - Run bit reads state; read-only when direct
// - Clear bit zeroes counter, capture untouched
// - Clear while running continues from zero
// - Direct enable hands run/lap to keys
// - Role swap bit exchanges run and lap pins
// - Accepted run key toggles run, raises event
// - Keys sampled per tick, release chatter filtered
// - Accepted lap key captures and holds, event
// - Decisecond overflow sets one-second flag
// - Entering hold copies one-second flag to carry
// - Three-bit code selects blocking mask keys
// - Presses during held mask key ignored
// - Alone, paired or with new mask accepted
// - Simultaneous means same sampling tick
//
package swk_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ    = 100_000_000;
  localparam int TICK_HZ   = 1024;
  localparam int TICK_DIV  = CLK_HZ / TICK_HZ;
  localparam int DEB_US    = 46800;
  localparam int DEB_TICKS = (DEB_US * TICK_HZ + 999_999) / 1_000_000;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_KEY_SWAP = 16'hFF06;
  localparam logic [15:0] ADDR_DIRECT   = 16'hFF78;
  localparam logic [15:0] ADDR_CTRL     = 16'hFF79;
  localparam logic [15:0] ADDR_MS       = 16'hFF7A;
  localparam logic [15:0] ADDR_CS       = 16'hFF7B;
  localparam logic [15:0] ADDR_DS       = 16'hFF7C;
  localparam logic [15:0] ADDR_EVENTS   = 16'hFF7D;

  // Field positions
  localparam int BIT_SWAP   = 2;
  localparam int BIT_DIRECT_KEY_ENABLE   = 3;
  localparam int BIT_CLR    = 0;
  localparam int BIT_RUN    = 1;
  localparam int BIT_RENEW  = 2;
  localparam int BIT_CARRY  = 3;
  localparam int BIT_ONESEC = 0;
  localparam int BIT_RUNEV  = 1;
  localparam int BIT_LAPEV  = 2;

  // Reset and digit values
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] BCD_MAX  = 4'h9;
  localparam logic [3:0] BCD_ONE  = 4'h1;

  // Mask keys selected by the key mask code, bit 0 = mask_key_a
  function automatic logic [5:0] mask_set(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    unique case (code)
      3'h0: m = 6'h00;
      3'h1: m = 6'h01;
      3'h2: m = 6'h03;
      3'h3: m = 6'h07;
      3'h4: m = 6'h04;
      3'h5: m = 6'h0C;
      3'h6: m = 6'h1C;
      3'h7: m = 6'h3C;
    endcase
    return m;
  endfunction

endpackage

//--- rtl/swk_stopwatch.sv
/*
  Stopwatch top: register port, run control, capture buffer with hold,
  and the direct run/lap key path with key mask.
  Assumes a single 100 MHz clock and asynchronous key pins.
*/
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module swk_stopwatch #(
  parameter int TICK_DIV  = swk_pkg::TICK_DIV,
  parameter int DEB_TICKS = swk_pkg::DEB_TICKS
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Register port
  input  wire logic [15:0] ADDR,
  input  wire logic [3:0]  WDATA,
  input  wire logic        WE,
  input  wire logic        RE,
  output logic      [3:0]  RDATA,
  // Key pins
  input  wire logic        KEY_PIN_A,
  input  wire logic        KEY_PIN_B,
  input  wire logic [5:0]  MASK_KEYS,
  // Status
  output logic             RUNNING,
  output logic             RUN_EVENT,
  output logic             LAP_EVENT
);
  import swk_pkg::*;

  localparam int TW = $clog2(TICK_DIV);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

  initial begin
    if (TICK_DIV < 2) $error("swk_stopwatch: TICK_DIV too small");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [TW-1:0] tdiv_reg;
  logic          tick_reg;
  logic          swap_reg;
  logic          direct_key_enable_req_reg;
  logic          direct_key_enable_reg;
  logic [2:0]    mask_sel_reg;
  logic          run_req_reg;
  logic          run_reg;
  logic          one_sec_reg;
  logic          run_ev_reg;
  logic          lap_ev_reg;
  logic          held_reg;
  logic          renewed_reg;
  logic          crnwf_reg;
  logic          lap_carry_request_flag_reg;
  logic [3:0]    cap_ms_reg;
  logic [3:0]    cap_cs_reg;
  logic [3:0]    cap_ds_reg;
  logic [5:0]    mask_prev_reg;
  logic [3:0]    rd_next;
  logic [3:0]    cnt_ms;
  logic [3:0]    cnt_cs;
  logic [3:0]    cnt_ds;
  logic          carry;
  logic [7:0]    key_raw;
  logic [7:0]    key_lvl;
  logic [7:0]    key_press;
  logic          run_press;
  logic          lap_press;
  logic          blocked;
  logic          run_accept;
  logic          lap_accept;
  logic          ms_rd;
  logic          cs_rd;
  logic          ds_rd;
  logic          clr_wr;
  logic          ctrl_wr;
  logic          ev_wr;
  logic          take_hold;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  assign ms_rd   = RE && (ADDR == ADDR_MS);
  assign cs_rd   = RE && (ADDR == ADDR_CS);
  assign ds_rd   = RE && (ADDR == ADDR_DS);
  assign ctrl_wr = WE && (ADDR == ADDR_CTRL);
  assign clr_wr  = ctrl_wr && WDATA[BIT_CLR];
  assign ev_wr   = WE && (ADDR == ADDR_EVENTS);

  // ---------------------------------------------------------------
  // 1,024 Hz sampling tick
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tdiv_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tdiv_reg == TICK_LAST);
      tdiv_reg <= (tdiv_reg == TICK_LAST) ? '0 : tdiv_reg + TW'(1);
    end
  end

  // ---------------------------------------------------------------
  // Software control registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      swap_reg     <= 1'b0;
      direct_key_enable_req_reg <= 1'b0;
      mask_sel_reg <= 3'h0;
    end else begin
      if (WE && ADDR == ADDR_KEY_SWAP) swap_reg <= WDATA[BIT_SWAP];
      if (WE && ADDR == ADDR_DIRECT) begin
        direct_key_enable_req_reg <= WDATA[BIT_DIRECT_KEY_ENABLE];
        mask_sel_reg <= WDATA[2:0];
      end
    end
  end

  // Direct mode switches over on the tick
  always_ff @(posedge CLK) begin
    if (SRST) begin
      direct_key_enable_reg <= 1'b0;
    end else if (tick_reg) begin
      direct_key_enable_reg <= direct_key_enable_req_reg;
    end
  end

  // ---------------------------------------------------------------
  // Run and stop
  // ---------------------------------------------------------------
  // Requested state, written by software or followed by the key
  always_ff @(posedge CLK) begin
    if (SRST) begin
      run_req_reg <= 1'b0;
    end else if (run_accept) begin
      run_req_reg <= ~run_reg;
    end else if (ctrl_wr && !direct_key_enable_reg) begin
      run_req_reg <= WDATA[BIT_RUN];
    end
  end

  // Actual state
  always_ff @(posedge CLK) begin
    if (SRST) begin
      run_reg <= 1'b0;
    end else if (run_accept) begin
      run_reg <= ~run_reg;
    end else if (tick_reg && !direct_key_enable_reg) begin
      run_reg <= run_req_reg;
    end
  end

  assign RUNNING = run_reg;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Counts on ticks while running, holds while stopped
  swk_bcd_chain u_count (
    .clk   (CLK),
    .srst  (SRST),
    .clr   (clr_wr),
    .inc   (tick_reg && run_reg),
    .ms    (cnt_ms),
    .cs    (cnt_cs),
    .ds    (cnt_ds),
    .carry (carry)
  );

  // ---------------------------------------------------------------
  // Event flags, write 1 to clear, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      one_sec_reg <= 1'b0;
      run_ev_reg  <= 1'b0;
      lap_ev_reg  <= 1'b0;
    end else begin
      one_sec_reg <= carry || (one_sec_reg && !(ev_wr && WDATA[BIT_ONESEC]));
      run_ev_reg  <= run_accept || (run_ev_reg && !(ev_wr && WDATA[BIT_RUNEV]));
      lap_ev_reg  <= lap_accept || (lap_ev_reg && !(ev_wr && WDATA[BIT_LAPEV]));
    end
  end

  // Event pulses
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RUN_EVENT <= 1'b0;
      LAP_EVENT <= 1'b0;
    end else begin
      RUN_EVENT <= run_accept;
      LAP_EVENT <= lap_accept;
    end
  end

  // ---------------------------------------------------------------
  // Direct keys
  // ---------------------------------------------------------------
  assign key_raw = {MASK_KEYS, KEY_PIN_B, KEY_PIN_A};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_key
      swk_key_filter #(
        .DEB_TICKS (DEB_TICKS)
      ) u_filt (
        .clk   (CLK),
        .srst  (SRST),
        .tick  (tick_reg),
        .raw   (key_raw[gi]),
        .level (key_lvl[gi]),
        .press (key_press[gi])
      );
    end
  endgenerate

  // Mask levels as they stood before the current sample
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mask_prev_reg <= 6'h00;
    end else if (tick_reg) begin
      mask_prev_reg <= key_lvl[7:2];
    end
  end

  // Role selection and concurrence judgement
  assign run_press  = swap_reg ? key_press[1] : key_press[0];
  assign lap_press  = swap_reg ? key_press[0] : key_press[1];
  assign blocked    = |(mask_prev_reg & mask_set(mask_sel_reg));
  assign run_accept = direct_key_enable_reg && run_press && !blocked;
  assign lap_accept = direct_key_enable_reg && lap_press && !blocked;

  // ---------------------------------------------------------------
  // Capture buffer and hold
  // ---------------------------------------------------------------
  assign take_hold = lap_accept || (ms_rd && !held_reg);

  // Buffer contents, latched as one word
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cap_ms_reg <= NIB_ZERO;
      cap_cs_reg <= NIB_ZERO;
      cap_ds_reg <= NIB_ZERO;
    end else if (take_hold) begin
      cap_ms_reg <= cnt_ms;
      cap_cs_reg <= cnt_cs;
      cap_ds_reg <= cnt_ds;
    end
  end

  // Hold state
  always_ff @(posedge CLK) begin
    if (SRST) begin
      held_reg <= 1'b0;
    end else if (take_hold) begin
      held_reg <= 1'b1;
    end else if (ds_rd && !renewed_reg) begin
      held_reg <= 1'b0;
    end
  end

  // Overwrite marker
  always_ff @(posedge CLK) begin
    if (SRST) begin
      renewed_reg <= 1'b0;
    end else if (lap_accept && held_reg) begin
      renewed_reg <= 1'b1;
    end else if (ds_rd) begin
      renewed_reg <= 1'b0;
    end
  end

  // Renewal flag, re-evaluated on each decisecond read without a lap capture in the same cycle
  always_ff @(posedge CLK) begin
    if (SRST) begin
      crnwf_reg <= 1'b0;
    end else if (ds_rd && !lap_accept) begin
      crnwf_reg <= held_reg && renewed_reg;
    end
  end

  // Carry request, copied when hold is entered
  always_ff @(posedge CLK) begin
    if (SRST) begin
      lap_carry_request_flag_reg <= 1'b0;
    end else if (take_hold) begin
      lap_carry_request_flag_reg <= one_sec_reg;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    rd_next = 4'h0;
    case (ADDR)
      ADDR_KEY_SWAP: rd_next[BIT_SWAP] = swap_reg;
      ADDR_DIRECT:   rd_next = {direct_key_enable_req_reg, mask_sel_reg};
      ADDR_CTRL:     rd_next = {lap_carry_request_flag_reg, crnwf_reg, run_reg, 1'b0};
      ADDR_MS:       rd_next = held_reg ? cap_ms_reg : cnt_ms;
      ADDR_CS:       rd_next = held_reg ? cap_cs_reg : cnt_cs;
      ADDR_DS:       rd_next = held_reg ? cap_ds_reg : cnt_ds;
      ADDR_EVENTS:   rd_next = {1'b0, lap_ev_reg, run_ev_reg, one_sec_reg};
      default:       rd_next = 4'h0;
    endcase
  end

  // Data stand only in the cycle after the read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 4'h0;
    end else begin
      RDATA <= RE ? rd_next : 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_ms_read_hold: assert property (@(posedge CLK) disable iff (SRST)
    ms_rd && !held_reg |=> held_reg && cap_ms_reg == $past(cnt_ms)
      && cap_ds_reg == $past(cnt_ds))
    else $error("millisecond read did not latch and hold");

  a_ds_releases: assert property (@(posedge CLK) disable iff (SRST)
    ds_rd && held_reg && !renewed_reg && !lap_accept |=> !held_reg)
    else $error("decisecond read did not release hold");

  a_held_stable: assert property (@(posedge CLK) disable iff (SRST)
    held_reg && !take_hold |=> $stable(cap_cs_reg) && $stable(cap_ds_reg))
    else $error("held buffer changed");

  a_live_read: assert property (@(posedge CLK) disable iff (SRST)
    cs_rd && !held_reg |=> RDATA == $past(cnt_cs))
    else $error("unheld read not live");

  a_lap_keeps_hold: assert property (@(posedge CLK) disable iff (SRST)
    ds_rd && held_reg && renewed_reg && !lap_accept |=> held_reg && crnwf_reg)
    else $error("read after overwrite released hold");

  a_renew_clear: assert property (@(posedge CLK) disable iff (SRST)
    ds_rd && !held_reg && !lap_accept |=> !crnwf_reg)
    else $error("renewal flag not cleared");

  a_run_on_tick: assert property (@(posedge CLK) disable iff (SRST)
    !tick_reg && !run_accept |=> $stable(run_reg))
    else $error("run state changed off tick");

  a_stop_keeps: assert property (@(posedge CLK) disable iff (SRST)
    !run_reg && !clr_wr |=> $stable(cnt_ms) && $stable(cnt_ds))
    else $error("stopped counter moved");

  a_direct_ro: assert property (@(posedge CLK) disable iff (SRST)
    direct_key_enable_reg && ctrl_wr && !run_accept |=> $stable(run_req_reg))
    else $error("run bit written in direct mode");

  a_clear_zero: assert property (@(posedge CLK) disable iff (SRST)
    clr_wr |=> cnt_ms == NIB_ZERO && cnt_cs == NIB_ZERO && cnt_ds == NIB_ZERO
      && $stable(held_reg))
    else $error("clear failed or touched hold");

  a_no_keys_off: assert property (@(posedge CLK) disable iff (SRST)
    !direct_key_enable_reg |-> !run_accept && !lap_accept)
    else $error("key accepted with direct input off");

  a_run_toggle: assert property (@(posedge CLK) disable iff (SRST)
    run_accept |=> run_reg != $past(run_reg) && RUN_EVENT && run_ev_reg)
    else $error("run key did not toggle");

  a_lap_capture: assert property (@(posedge CLK) disable iff (SRST)
    lap_accept |=> held_reg && LAP_EVENT && cap_cs_reg == $past(cnt_cs))
    else $error("lap key did not capture");

  a_one_second: assert property (@(posedge CLK) disable iff (SRST)
    carry |=> one_sec_reg)
    else $error("overflow did not set one-second flag");

  a_carry_copy: assert property (@(posedge CLK) disable iff (SRST)
    take_hold |=> lap_carry_request_flag_reg == $past(one_sec_reg))
    else $error("carry request not copied");

  a_mask_blocks: assert property (@(posedge CLK) disable iff (SRST)
    blocked |-> !run_accept && !lap_accept)
    else $error("press accepted under mask");

endmodule
`default_nettype wire

//--- sim/swk_key_model.sv
/*
  Push-button model for the run, lap and mask keys, with release bounce.
  Assumes the bench calls its tasks; keys read high while pressed.
*/
`timescale 1ns/1ns
`default_nettype none
module swk_key_model #(
  parameter int TICK = 16
) (
  // Clock
  input  wire logic       clk,
  // Key pins
  output logic            key_a,
  output logic            key_b,
  output logic [5:0]      mask
);
  // -------------------------------------------------------------
  // Key drive
  // -------------------------------------------------------------
  // Released keys rest low, like a pull-down
  initial begin
    key_a = 1'b0;
    key_b = 1'b0;
    mask  = 6'h00;
  end

  // Hold a key pattern for a number of sampling ticks
  task automatic drive(input logic a, input logic b, input logic [5:0] m, input int n);
    @(posedge clk);
    key_a <= a;
    key_b <= b;
    mask  <= m;
    repeat (n * TICK) @(posedge clk);
  endtask

  // Press, release with one bounce, then rest long enough to re-arm
  task automatic tap(input logic a, input logic b, input logic [5:0] m);
    drive(a, b, m, 3);
    drive(1'b0, 1'b0, m, 1);
    drive(a, b, m, 1);
    drive(1'b0, 1'b0, 6'h00, 6);
  endtask
endmodule
`default_nettype wire

//--- sim/swk_stopwatch_tb.sv
/*
  Self-checking bench for the stopwatch block: register reads and writes,
  capture hold, clear, run control and direct keys with mask.
  Assumes a short tick divider and debounce count for run time.
*/
`timescale 1ns/1ns
`default_nettype none
module swk_stopwatch_tb;
  import swk_pkg::*;
  localparam int TD = 16;
  logic        clk;
  logic        srst;
  logic        we;
  logic        re;
  logic        key_a;
  logic        key_b;
  logic [15:0] addr;
  logic [3:0]  wdata;
  logic [3:0]  rdata;
  logic [3:0]  v;
  logic [3:0]  x;
  logic [5:0]  mask;
  logic        running;
  logic        run_ev;
  logic        lap_ev;
  int          fails = 0;
  int          tests_run = 0;
  int          nrun = 0;
  int          nlap = 0;
  int          i;
  logic [5:0]  sel [8] = '{6'h01, 6'h01, 6'h02, 6'h04, 6'h04, 6'h08, 6'h10, 6'h20};

  swk_stopwatch #(.TICK_DIV(TD), .DEB_TICKS(3)) u_swk_stopwatch (
    .CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
    .RDATA(rdata), .KEY_PIN_A(key_a), .KEY_PIN_B(key_b), .MASK_KEYS(mask),
    .RUNNING(running), .RUN_EVENT(run_ev), .LAP_EVENT(lap_ev));

  swk_key_model #(.TICK(TD)) u_swk_key_model (
    .clk(clk), .key_a(key_a), .key_b(key_b), .mask(mask));

  // -------------------------------------------------------------
  // Clock, event counting and tasks
  // -------------------------------------------------------------
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count event pulses
  always @(posedge clk) begin
    if (run_ev === 1'b1) nrun <= nrun + 1;
    if (lap_ev === 1'b1) nlap <= nlap + 1;
  end

  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [3:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic tk(input int n);
    repeat (n * TD) @(posedge clk);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [3:0] m, input logic [3:0] e);
    rd(a, v);
    chk(v & m, e);
  endtask

  task automatic test_done;
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    srst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 16'h0000;
    wdata = 4'h0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rdc(ADDR_CTRL, 4'hF, 4'h0);
    rdc(ADDR_MS, 4'hF, 4'h0);
    rdc(ADDR_CS, 4'hF, 4'h0);
    rdc(ADDR_DS, 4'hF, 4'h0);
    rdc(16'hFFFF, 4'hF, 4'h0);
    // Software run, stop and live versus held reads
    wr(ADDR_CTRL, 4'h2);
    tk(2);
    chk({3'h0, running}, 4'h1);
    rdc(ADDR_CTRL, 4'h2, 4'h2);
    tk(30);
    wr(ADDR_CTRL, 4'h0);
    tk(2);
    chk({3'h0, running}, 4'h0);
    rd(ADDR_CS, x);
    chk({3'h0, x == 4'h0}, 4'h0);
    rd(ADDR_MS, v);
    wr(ADDR_CTRL, 4'h1);
    rdc(ADDR_CS, 4'hF, x);
    rdc(ADDR_DS, 4'hF, 4'h0);
    rdc(ADDR_MS, 4'hF, 4'h0);
    rdc(ADDR_CS, 4'hF, 4'h0);
    rdc(ADDR_DS, 4'hF, 4'h0);
    // Clear while running keeps counting
    wr(ADDR_CTRL, 4'h2);
    tk(40);
    wr(ADDR_CTRL, 4'h3);
    tk(5);
    rd(ADDR_MS, v);
    chk({3'h0, v == 4'h0}, 4'h0);
    rdc(ADDR_CS, 4'hF, 4'h0);
    rd(ADDR_DS, v);
    // One-second flag and carry request
    v = 4'h0;
    for (i = 0; i < 120 && v[0] !== 1'b1; i++) begin
      tk(10);
      rd(ADDR_EVENTS, v);
    end
    chk(v & 4'h1, 4'h1);
    if (v[0] !== 1'b1) test_done();
    rd(ADDR_MS, v);
    rdc(ADDR_CTRL, 4'h8, 4'h8);
    rd(ADDR_CS, v);
    rd(ADDR_DS, v);
    wr(ADDR_EVENTS, 4'h1);
    rd(ADDR_MS, v);
    rdc(ADDR_CTRL, 4'h8, 4'h0);
    rd(ADDR_CS, v);
    rd(ADDR_DS, v);
    wr(ADDR_CTRL, 4'h0);
    tk(2);
    // Direct keys: run write ignored, run and lap keys
    wr(ADDR_DIRECT, 4'h8);
    tk(2);
    wr(ADDR_CTRL, 4'h2);
    tk(2);
    chk({3'h0, running}, 4'h0);
    u_swk_key_model.tap(1'b1, 1'b0, 6'h00);
    chk({3'h0, running}, 4'h1);
    u_swk_key_model.tap(1'b0, 1'b1, 6'h00);
    u_swk_key_model.tap(1'b0, 1'b1, 6'h00);
    chk(4'(nlap), 4'h2);
    rdc(ADDR_EVENTS, 4'h6, 4'h6);
    wr(ADDR_EVENTS, 4'h6);
    rdc(ADDR_EVENTS, 4'h6, 4'h0);
    rd(ADDR_CS, v);
    rd(ADDR_DS, v);
    rdc(ADDR_CTRL, 4'h4, 4'h4);
    rd(ADDR_CS, x);
    tk(12);
    rdc(ADDR_CS, 4'hF, x);
    rd(ADDR_MS, v);
    rd(ADDR_DS, v);
    rdc(ADDR_CTRL, 4'h4, 4'h0);
    u_swk_key_model.tap(1'b1, 1'b1, 6'h00);
    chk(4'(nrun), 4'h2);
    chk(4'(nlap), 4'h3);
    wr(ADDR_KEY_SWAP, 4'h4);
    u_swk_key_model.tap(1'b0, 1'b1, 6'h00);
    chk(4'(nrun), 4'h3);
    chk(4'(nlap), 4'h3);
    wr(ADDR_KEY_SWAP, 4'h0);
    // Mask codes: a held selected key blocks, code 0 blocks nothing
    for (i = 0; i < 8; i++) begin
      wr(ADDR_DIRECT, 4'h8 | 4'(i));
      tk(2);
      u_swk_key_model.drive(1'b0, 1'b0, sel[i], 2);
      u_swk_key_model.tap(1'b1, 1'b0, sel[i]);
    end
    chk(4'(nrun), 4'h4);
    wr(ADDR_DIRECT, 4'h9);
    tk(2);
    u_swk_key_model.tap(1'b1, 1'b0, 6'h01);
    chk(4'(nrun), 4'h5);
    u_swk_key_model.drive(1'b0, 1'b0, 6'h01, 2);
    u_swk_key_model.drive(1'b1, 1'b0, 6'h01, 3);
    u_swk_key_model.drive(1'b1, 1'b0, 6'h00, 3);
    u_swk_key_model.drive(1'b0, 1'b0, 6'h00, 6);
    chk(4'(nrun), 4'h5);
    // Direct mode off: keys ignored, software control again
    wr(ADDR_DIRECT, 4'h0);
    tk(2);
    u_swk_key_model.tap(1'b1, 1'b0, 6'h00);
    chk(4'(nrun), 4'h5);
    wr(ADDR_CTRL, 4'h0);
    tk(2);
    chk({3'h0, running}, 4'h0);
    test_done();
  end
endmodule
`default_nettype wire
